// ### bic_params.svh
/*
  Constants for the board-information command handler: parameter block
  and register offsets, field positions, reset values, snapshot layout.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BIC_PARAMS_SVH
`define BIC_PARAMS_SVH

// Command codes
`define BIC_CMD_BOARD_INFO 8'h15
`define BIC_ADAPTER_CTRL_ID 8'hff

// Register byte offsets (12-bit decode)
`define BIC_OFF_PB_ID 12'h000
`define BIC_OFF_PB_AM 12'h004
`define BIC_OFF_PB_ADDR 12'h008
`define BIC_OFF_PB_RSV 12'h00c
`define BIC_OFF_PB_CMD 12'h010
`define BIC_OFF_CTRL 12'h014
`define BIC_OFF_STAT 12'h018
`define BIC_OFF_GENCFG 12'h01c
`define BIC_OFF_OPTCFG 12'h020
`define BIC_TGT_BASE_IDX 8'h04
`define BIC_TGT_LAST_IDX 8'h13
`define BIC_TGT_REG_WORDS 2'h3

// Field positions
`define BIC_FMT_BIT 1
`define BIC_START_BIT 0
`define BIC_BUSY_BIT 0
`define BIC_DONE_BIT 1
`define BIC_ERR_BIT 2
`define BIC_SEL_DIS 0
`define BIC_SEL_PAR 1
`define BIC_SEL_BMT 2
`define BIC_THROTTLE_MAX 4'hb

// Reset values
`define BIC_GENCFG_RST 32'h0000_0000
`define BIC_OPTCFG_RST 32'h0000_0000
`define BIC_WORD_ZERO 32'h0000_0000

// Snapshot layout in words
`define BIC_HDR_WORDS 8'h04
`define BIC_TGT_WORDS 8'h08
`define BIC_LAST_8 8'h43
`define BIC_LAST_16 8'h83
`define BIC_HW_REV 3'h0
`define BIC_HW_OPT 3'h1
`define BIC_HW_MODEL 3'h3
`define BIC_TW_SENSE 3'h1
`define BIC_TW_SYNC 3'h2
`define BIC_TW_WIDTH 3'h3

`endif

// ### bic_pkg.sv
/*
  Types for the board-information command handler.
  Assumes nothing of its surroundings.
*/
package bic_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_REL} seq_state_t;
  typedef logic [31:0] word_t;
endpackage

// ### bic_word_fmt.sv
/*
  Snapshot word formatter: builds one big-endian word of the snapshot
  from its word index and the current board settings.
  Assumes the caller supplies the entry of the target the index selects.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bic_params.svh"

module bic_word_fmt (
  // Word selection
  input wire logic [7:0] word_idx,
  // Board settings
  input wire logic [7:0] fw_rev,
  input wire logic [7:0] eng_rev,
  input wire logic [3:0] throttle,
  input wire logic [2:0] sel_flags,
  input wire logic [3:0] adapter_tid,
  input wire logic bus_reset_sel,
  input wire logic [7:0] day,
  input wire logic [7:0] month,
  input wire logic [7:0] year,
  input wire logic [15:0] base_model,
  // Selected target entry
  input wire logic [7:0] tgt_sense,
  input wire logic [31:0] tgt_sync,
  input wire logic [7:0] tgt_width,
  // Result
  output bic_pkg::word_t word
);
  logic [7:0] opt_flags;
  logic [7:0] tw;

  always_comb begin
    // Id bits 2..0 high, reset setting, id bit 3 low
    opt_flags = {adapter_tid[2:0], bus_reset_sel, 1'b0, 1'b0, 1'b0,
      adapter_tid[3]};
    tw = word_idx - `BIC_HDR_WORDS;
    word = `BIC_WORD_ZERO;
    if (word_idx < `BIC_HDR_WORDS) begin
      unique case (word_idx[2:0])
        `BIC_HW_REV: word = {fw_rev, eng_rev, 4'h0, throttle, 5'h00,
          sel_flags};
        `BIC_HW_OPT: word = {opt_flags, day, month, year};
        `BIC_HW_MODEL: word = {base_model, 16'h0000};
        default: word = `BIC_WORD_ZERO;
      endcase
    end else begin
      // Sense byte returns in the top byte; target words 0 and 4 to 7 return as zero
      unique case (tw[2:0])
        `BIC_TW_SENSE: word = {tgt_sense, 24'h000000};
        `BIC_TW_SYNC: word = tgt_sync;
        `BIC_TW_WIDTH: word = {tgt_width, 24'h000000};
        default: word = `BIC_WORD_ZERO;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### board_info_cmd.sv
/*
  Board-information command handler: AHB-Lite register slave holding the
  parameter block and board settings, and a bus master that writes the
  configuration snapshot into host memory, one word per handshake.
  Assumes vme_ack is a four-phase acknowledge from another clock domain.
*/
// Contract
// - Command code 15H requests snapshot
// - Drive modifier byte from 04H
// - Snapshot starts at address from 08H
// - Format bit picks 8 or 16 targets
// - Target blocks ascending from target 0
// - Header fields at 00H, 04H, 0CH
// - Target fields at 14H, 18H, 1CH, 20H; the code fills 14H, 18H, 1CH and writes 20H as zero
// - Select bit 0 reports disconnect allowed
// - Select bit 1 reports parity checking
// - Select bit 2 reports block-transfer policy
// - Throttle exponent 00H to 0BH
// - Day, month, year give build date
// - Option flags carry id and reset
// - Reset bit shows bus reset setting
`timescale 1ns/1ps
`default_nettype none
`include "bic_params.svh"

module board_info_cmd #(
  parameter logic [15:0] BASE_MODEL = 16'h0001 // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Host memory write master
  output logic [31:0] vme_addr,
  output logic [5:0] vme_am,
  output logic [31:0] vme_data,
  output logic vme_wr_req,
  input wire logic vme_ack
);
  bic_pkg::seq_state_t state_ff, nxt_state;
  logic wr_en_ff, nxt_wr_en;
  logic [11:0] wr_addr_ff, nxt_wr_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [31:0] pb_id_ff, nxt_pb_id;
  logic [7:0] pb_am_ff, nxt_pb_am;
  logic [7:0] pb_aid_ff, nxt_pb_aid;
  logic [31:0] pb_addr_ff, nxt_pb_addr;
  logic [7:0] pb_cmd_ff, nxt_pb_cmd;
  logic [7:0] pb_opt_ff, nxt_pb_opt;
  logic [31:0] gen_ff, nxt_gen;
  logic [31:0] opt_ff, nxt_opt;
  logic [31:0] tbl_ff [16][3];
  logic [31:0] nxt_tbl [16][3];
  logic done_ff, nxt_done;
  logic err_ff, nxt_err;
  logic [7:0] idx_ff, nxt_idx;
  logic [31:0] vaddr_ff, nxt_vaddr;
  logic [5:0] vam_ff, nxt_vam;
  logic [31:0] vdata_ff, nxt_vdata;
  logic vreq_ff, nxt_vreq;
  logic ack_m_ff, ack_s_ff;
  logic rd_take, start, cmd_ok, last;
  logic [7:0] fmt_idx, rel_idx, tgt_sel, wr_tidx;
  logic [1:0] wr_word;
  logic wr_tgt;
  logic [31:0] fmt_word, gen_w;
  logic [3:0] thr_w;

  // Only the second stage is read anywhere
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ack_m_ff <= 1'b0;
      ack_s_ff <= 1'b0;
    end else begin
      ack_m_ff <= vme_ack;
      ack_s_ff <= ack_m_ff;
    end
  end

  // Bus decode
  always_comb begin
    rd_take = hsel & hready & htrans[1] & ~hwrite;
    nxt_wr_en = hsel & hready & htrans[1] & hwrite;
    nxt_wr_addr = haddr[11:0];
    rel_idx = haddr[11:4] - `BIC_TGT_BASE_IDX;
    nxt_rdata = `BIC_WORD_ZERO;
    if (rd_take) begin
      unique case (haddr[11:0])
        `BIC_OFF_PB_ID: nxt_rdata = pb_id_ff;
        `BIC_OFF_PB_AM: nxt_rdata = {16'h0000, pb_am_ff, pb_aid_ff};
        `BIC_OFF_PB_ADDR: nxt_rdata = pb_addr_ff;
        `BIC_OFF_PB_CMD: nxt_rdata = {pb_cmd_ff, pb_opt_ff, 16'h0000};
        `BIC_OFF_STAT: nxt_rdata = {29'h0, err_ff, done_ff,
          state_ff != bic_pkg::ST_IDLE};
        `BIC_OFF_GENCFG: nxt_rdata = gen_ff;
        `BIC_OFF_OPTCFG: nxt_rdata = opt_ff;
        default: begin
          if (haddr[11:4] >= `BIC_TGT_BASE_IDX &&
              haddr[11:4] <= `BIC_TGT_LAST_IDX &&
              haddr[3:2] != `BIC_TGT_REG_WORDS) begin
            nxt_rdata = tbl_ff[rel_idx[3:0]][haddr[3:2]];
          end
        end
      endcase
    end
  end

  // Register writes in the data phase
  always_comb begin
    nxt_pb_id = pb_id_ff;
    nxt_pb_am = pb_am_ff;
    nxt_pb_aid = pb_aid_ff;
    nxt_pb_addr = pb_addr_ff;
    nxt_pb_cmd = pb_cmd_ff;
    nxt_pb_opt = pb_opt_ff;
    nxt_gen = gen_ff;
    nxt_opt = opt_ff;
    nxt_tbl = tbl_ff;
    start = 1'b0;
    wr_tidx = wr_addr_ff[11:4] - `BIC_TGT_BASE_IDX;
    wr_word = wr_addr_ff[3:2];
    wr_tgt = wr_addr_ff[11:4] >= `BIC_TGT_BASE_IDX &&
      wr_addr_ff[11:4] <= `BIC_TGT_LAST_IDX &&
      wr_word != `BIC_TGT_REG_WORDS;
    // Oversized exponents are held at the largest burst
    thr_w = (hwdata[19:16] > `BIC_THROTTLE_MAX) ? `BIC_THROTTLE_MAX :
      hwdata[19:16];
    gen_w = {hwdata[31:16] & 16'hffff, 4'h0, thr_w, 5'h00, hwdata[2:0]};
    if (wr_en_ff) begin
      unique case (wr_addr_ff)
        `BIC_OFF_PB_ID: nxt_pb_id = hwdata;
        `BIC_OFF_PB_AM: begin
          nxt_pb_am = hwdata[15:8];
          nxt_pb_aid = hwdata[7:0];
        end
        `BIC_OFF_PB_ADDR: nxt_pb_addr = hwdata;
        `BIC_OFF_PB_CMD: begin
          nxt_pb_cmd = hwdata[31:24];
          nxt_pb_opt = hwdata[23:16];
        end
        `BIC_OFF_CTRL: start = hwdata[`BIC_START_BIT];
        `BIC_OFF_GENCFG: nxt_gen = {gen_w[31:24], gen_w[23:16],
          gen_w[15:0]};
        `BIC_OFF_OPTCFG: nxt_opt = {hwdata[31:8], 3'h0, hwdata[4:0]};
        default: begin
          if (wr_tgt) begin
            nxt_tbl[wr_tidx[3:0]][wr_word] = hwdata;
          end
        end
      endcase
    end
  end

  // Snapshot sequencer
  always_comb begin
    cmd_ok = pb_cmd_ff == `BIC_CMD_BOARD_INFO &&
      pb_aid_ff == `BIC_ADAPTER_CTRL_ID;
    last = pb_opt_ff[`BIC_FMT_BIT] ? (idx_ff == `BIC_LAST_16) :
      (idx_ff == `BIC_LAST_8);
    fmt_idx = (state_ff == bic_pkg::ST_IDLE) ? 8'h00 : idx_ff + 8'h01;
    tgt_sel = (fmt_idx - `BIC_HDR_WORDS) >> 3;
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_vaddr = vaddr_ff;
    nxt_vam = vam_ff;
    nxt_vdata = vdata_ff;
    nxt_vreq = vreq_ff;
    // A new completion wins over a clearing write
    nxt_done = done_ff & ~(wr_en_ff && wr_addr_ff == `BIC_OFF_STAT &&
      hwdata[`BIC_DONE_BIT]);
    nxt_err = err_ff & ~(wr_en_ff && wr_addr_ff == `BIC_OFF_STAT &&
      hwdata[`BIC_ERR_BIT]);
    unique case (state_ff)
      bic_pkg::ST_IDLE: begin
        if (start && cmd_ok) begin
          nxt_state = bic_pkg::ST_REQ;
          nxt_idx = 8'h00;
          nxt_vaddr = pb_addr_ff;
          nxt_vam = pb_am_ff[5:0];
          nxt_vdata = fmt_word;
          nxt_vreq = 1'b1;
        end else if (start) begin
          nxt_err = 1'b1;
        end
      end
      bic_pkg::ST_REQ: begin
        if (ack_s_ff) begin
          nxt_state = bic_pkg::ST_REL;
          nxt_vreq = 1'b0;
        end
      end
      bic_pkg::ST_REL: begin
        if (!ack_s_ff) begin
          if (last) begin
            nxt_state = bic_pkg::ST_IDLE;
            nxt_done = 1'b1;
          end else begin
            nxt_state = bic_pkg::ST_REQ;
            nxt_idx = fmt_idx;
            nxt_vaddr = vaddr_ff + 32'h0000_0004;
            nxt_vdata = fmt_word;
            nxt_vreq = 1'b1;
          end
        end
      end
    endcase
  end

  bic_word_fmt u_fmt (
    .word_idx(fmt_idx),
    .fw_rev(gen_ff[31:24]),
    .eng_rev(gen_ff[23:16]),
    .throttle(gen_ff[11:8]),
    .sel_flags(gen_ff[2:0]),
    .adapter_tid(opt_ff[3:0]),
    .bus_reset_sel(opt_ff[4]),
    .day(opt_ff[15:8]),
    .month(opt_ff[23:16]),
    .year(opt_ff[31:24]),
    .base_model(BASE_MODEL),
    .tgt_sense(tbl_ff[tgt_sel[3:0]][0][7:0]),
    .tgt_sync(tbl_ff[tgt_sel[3:0]][1]),
    .tgt_width(tbl_ff[tgt_sel[3:0]][2][7:0]),
    .word(fmt_word)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= bic_pkg::ST_IDLE;
      wr_en_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      rdata_ff <= `BIC_WORD_ZERO;
      pb_id_ff <= `BIC_WORD_ZERO;
      pb_am_ff <= 8'h00;
      pb_aid_ff <= 8'h00;
      pb_addr_ff <= `BIC_WORD_ZERO;
      pb_cmd_ff <= 8'h00;
      pb_opt_ff <= 8'h00;
      gen_ff <= `BIC_GENCFG_RST;
      opt_ff <= `BIC_OPTCFG_RST;
      for (int t = 0; t < 16; t++) begin
        for (int w = 0; w < 3; w++) begin
          tbl_ff[t][w] <= `BIC_WORD_ZERO;
        end
      end
      done_ff <= 1'b0;
      err_ff <= 1'b0;
      idx_ff <= 8'h00;
      vaddr_ff <= `BIC_WORD_ZERO;
      vam_ff <= 6'h00;
      vdata_ff <= `BIC_WORD_ZERO;
      vreq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wr_en_ff <= nxt_wr_en;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff <= nxt_rdata;
      pb_id_ff <= nxt_pb_id;
      pb_am_ff <= nxt_pb_am;
      pb_aid_ff <= nxt_pb_aid;
      pb_addr_ff <= nxt_pb_addr;
      pb_cmd_ff <= nxt_pb_cmd;
      pb_opt_ff <= nxt_pb_opt;
      gen_ff <= nxt_gen;
      opt_ff <= nxt_opt;
      tbl_ff <= nxt_tbl;
      done_ff <= nxt_done;
      err_ff <= nxt_err;
      idx_ff <= nxt_idx;
      vaddr_ff <= nxt_vaddr;
      vam_ff <= nxt_vam;
      vdata_ff <= nxt_vdata;
      vreq_ff <= nxt_vreq;
    end
  end

  // Zero wait states, always OKAY
  assign hrdata = rdata_ff;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign vme_addr = vaddr_ff;
  assign vme_am = vam_ff;
  assign vme_data = vdata_ff;
  assign vme_wr_req = vreq_ff;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_go;
    state_ff == bic_pkg::ST_IDLE && start && cmd_ok;
  endsequence
  sequence s_beat_end;
    state_ff == bic_pkg::ST_REL && !ack_s_ff && !last;
  endsequence

  a_cmd_gate: assert property (
    state_ff == bic_pkg::ST_IDLE && start && !cmd_ok |=> !vme_wr_req && err_ff)
    else $error("request raised for a foreign command");
  a_am_drive: assert property (
    s_go |=> vme_am == $past(pb_am_ff[5:0]))
    else $error("modifier not taken from the parameter block");
  a_first_addr: assert property (
    s_go |=> vme_wr_req && vme_addr == $past(pb_addr_ff) && idx_ff == 8'h00)
    else $error("first word not at the requested address");
  a_addr_step: assert property (
    s_beat_end |=> vme_addr == $past(vaddr_ff) + 32'h0000_0004)
    else $error("snapshot words not written in ascending order");
  a_fmt_length: assert property (
    state_ff == bic_pkg::ST_REL && !ack_s_ff && last |->
      idx_ff == (pb_opt_ff[`BIC_FMT_BIT] ? `BIC_LAST_16 : `BIC_LAST_8))
    else $error("snapshot length does not follow the format bit");
  a_hdr_flags: assert property (
    vme_wr_req && idx_ff == 8'h00 |->
      vme_data[7:0] == {5'h00, gen_ff[2:0]} &&
      vme_data[11:8] <= `BIC_THROTTLE_MAX)
    else $error("select flags or throttle wrong in header");
  a_opt_flags: assert property (
    vme_wr_req && idx_ff == 8'h01 |->
      vme_data[31:24] == {opt_ff[2:0], opt_ff[4], 3'h0, opt_ff[3]})
    else $error("option flags byte wrong");
  a_req_hold: assert property (
    vme_wr_req && !ack_s_ff |=> vme_wr_req && $stable(vme_data))
    else $error("word dropped before acknowledge");
  a_done_end: assert property (
    state_ff == bic_pkg::ST_REL && !ack_s_ff && last |=> done_ff &&
      state_ff == bic_pkg::ST_IDLE)
    else $error("completion not flagged after last word");
endmodule
`default_nettype wire

// ### host_mem_model.sv
/*
  Host memory model: accepts snapshot words over the four-phase write
  handshake and logs address, modifier and data of each one.
  Assumes the writer holds its request until it sees the acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none

module host_mem_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pacing
  input wire logic slow,
  // Write port
  input wire logic [31:0] vme_addr,
  input wire logic [5:0] vme_am,
  input wire logic [31:0] vme_data,
  input wire logic vme_wr_req,
  output logic vme_ack
);
  logic [31:0] cap_addr [0:511];
  logic [31:0] cap_data [0:511];
  logic [5:0] cap_am [0:511];
  int cap_cnt = 0;
  logic hold_bad = 1'b0;

  initial begin
    vme_ack = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (rst_n === 1'b1 && vme_wr_req === 1'b1) begin
        // Slow host stretches the wait for the acknowledge
        repeat (slow ? 5 : 0) @(posedge clk_sys);
        cap_addr[cap_cnt] = vme_addr;
        cap_data[cap_cnt] = vme_data;
        cap_am[cap_cnt] = vme_am;
        cap_cnt++;
        vme_ack <= 1'b1;
        do begin
          @(posedge clk_sys);
          // Only held words count; data may move as the request drops
          if (vme_wr_req === 1'b1 &&
              vme_data !== cap_data[cap_cnt - 1]) begin
            hold_bad = 1'b1;
          end
        end while (vme_wr_req === 1'b1);
        vme_ack <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// ### board_info_command_handler_tb.sv
/*
  Testbench for the board-information command handler: programs it over
  AHB-Lite and checks the snapshot logged by the host memory model.
  Assumes zero-wait-state slave and registered read data.
*/
`timescale 1ns/1ps
`default_nettype none
`include "bic_params.svh"

module board_info_command_handler_tb;
  typedef struct {
    logic [31:0] gen, opt, base, w0, w1;
    logic [7:0] am;
    logic fmt, slow;
  } row_t;
  localparam logic [15:0] MODEL = 16'h5a01; // Arbitrary value
  localparam logic [31:0] A_AM = {20'h0, `BIC_OFF_PB_AM};
  localparam logic [31:0] A_CMD = {20'h0, `BIC_OFF_PB_CMD};
  localparam logic [31:0] A_CTRL = {20'h0, `BIC_OFF_CTRL};
  localparam logic [31:0] A_STAT = {20'h0, `BIC_OFF_STAT};
  localparam logic [31:0] A_GEN = {20'h0, `BIC_OFF_GENCFG};
  localparam logic [31:0] A_OPT = {20'h0, `BIC_OFF_OPTCFG};
  logic clk_sys;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic slow = 1'b0;
  wire hready;
  logic [31:0] hrdata, vme_addr, vme_data;
  logic hreadyout, hresp, vme_wr_req, vme_ack;
  logic [5:0] vme_am;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] cmd_id = 32'h0;
  // Rows: gen, opt, base, header w0, header w1, modifier, format, slow
  row_t rows [3] = '{
    '{32'h2130_0005, 32'h970c_1ff5, 32'h0010_0000, 32'h2130_0005,
      32'hb01f_0c97, 8'h3d, 1'b0, 1'b0},
    '{32'h4c5b_0b02, 32'h9801_020a, 32'h0020_0040, 32'h4c5b_0b02,
      32'h4102_0198, 8'h09, 1'b1, 1'b1},
    '{32'h0f3e_0e00, 32'h0000_001f, 32'hfff0_0000, 32'h0f3e_0b00,
      32'hf100_0000, 8'hff, 1'b0, 1'b0}};

  assign hready = hreadyout;

  board_info_cmd #(.BASE_MODEL(MODEL)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .vme_addr(vme_addr), .vme_am(vme_am),
    .vme_data(vme_data), .vme_wr_req(vme_wr_req), .vme_ack(vme_ack));

  host_mem_model u_host (
    .clk_sys(clk_sys), .rst_n(rst_n), .slow(slow), .vme_addr(vme_addr),
    .vme_am(vme_am), .vme_data(vme_data), .vme_wr_req(vme_wr_req),
    .vme_ack(vme_ack));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] exp_word(input row_t r, input int i);
    int t;
    t = (i - 4) / 8;
    if (i < 4) begin
      return (i == 0) ? r.w0 : (i == 1) ? r.w1 :
             (i == 3) ? {MODEL, 16'h0} : 32'h0;
    end
    case ((i - 4) % 8)
      1: return {8'h10 + t[7:0], 24'h0};
      2: return {8'h20 + t[7:0], 8'h40 + t[7:0], 8'h80, t[7:0]};
      3: return {8'h60 + t[7:0], 24'h0};
      default: return 32'h0;
    endcase
  endfunction

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask

  task automatic rd_chk(input string nm, input logic [31:0] a, e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    chk(nm, e, v);
  endtask

  task automatic wait_stat(input logic [31:0] m);
    logic [31:0] v;
    int n;
    v = 32'h0;
    n = 0;
    // Bounded poll; a stuck status ends up as a mismatch
    while ((v & m) !== m && n < 4000) begin
      ahb(1'b0, A_STAT, 32'h0, v);
      n++;
    end
    chk("status bit", m, v & m);
  endtask

  task automatic prog(input row_t r, input logic [7:0] cmd, id);
    wr(A_GEN, r.gen);
    wr(A_OPT, r.opt);
    wr(A_AM, {16'h0, r.am, id});
    wr({20'h0, `BIC_OFF_PB_ADDR}, r.base);
    wr({20'h0, `BIC_OFF_PB_ID}, cmd_id);
    cmd_id = cmd_id + 32'h1;
    wr(A_CMD, {cmd, 6'h0, r.fmt, 1'b0, 16'h0});
  endtask

  initial begin
    int i, k, n0, nw;
    logic [31:0] v;
    logic [7:0] bad [2][2];
    bad = '{'{8'h16, 8'hff}, '{8'h15, 8'hfe}};
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("hrdata", 32'h0, hrdata);
    chk("wr_req", 32'h0, {31'h0, vme_wr_req});
    chk("hreadyout", 32'h1, {31'h0, hreadyout});
    chk("hresp", 32'h0, {31'h0, hresp});
    rd_chk("gencfg", A_GEN, `BIC_GENCFG_RST);
    rd_chk("optcfg", A_OPT, `BIC_OPTCFG_RST);
    rd_chk("status", A_STAT, 32'h0);
    $display("test reset done");
    for (i = 0; i < 16; i++) begin
      wr(32'h40 + i * 16, {24'hffffff, 8'h10 + i[7:0]});
      wr(32'h44 + i * 16, {8'h20 + i[7:0], 8'h40 + i[7:0], 8'h80, i[7:0]});
      wr(32'h48 + i * 16, {24'hffffff, 8'h60 + i[7:0]});
    end
    for (i = 0; i < 3; i++) begin
      n0 = u_host.cap_cnt;
      slow <= rows[i].slow;
      prog(rows[i], `BIC_CMD_BOARD_INFO, `BIC_ADAPTER_CTRL_ID);
      wr(A_CTRL, 32'h1);
      wait_stat(32'h2);
      nw = rows[i].fmt ? 132 : 68;
      chk("word count", nw, u_host.cap_cnt - n0);
      for (k = 0; k < nw; k++) begin
        chk("addr", rows[i].base + 4 * k, u_host.cap_addr[n0 + k]);
        chk("am", {26'h0, rows[i].am[5:0]}, {26'h0, u_host.cap_am[n0 + k]});
        chk("word", exp_word(rows[i], k), u_host.cap_data[n0 + k]);
      end
      chk("hold", 32'h0, {31'h0, u_host.hold_bad});
      wr(A_STAT, 32'h2);
      rd_chk("status clear", A_STAT, 32'h0);
      $display("test row %0d done", i);
    end
    n0 = u_host.cap_cnt;
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h1);
    ahb(1'b0, A_STAT, 32'h0, v);
    chk("busy", 32'h1, v & 32'h1);
    wait_stat(32'h2);
    chk("restart ignored", 32'h44, u_host.cap_cnt - n0);
    wr(A_STAT, 32'h2);
    $display("test busy start done");
    for (i = 0; i < 2; i++) begin
      n0 = u_host.cap_cnt;
      prog(rows[2], bad[i][0], bad[i][1]);
      wr(A_CTRL, 32'h1);
      wait_stat(32'h4);
      chk("no words", 32'h0, u_host.cap_cnt - n0);
      wr(A_STAT, 32'h4);
      rd_chk("error clear", A_STAT, 32'h0);
    end
    $display("test refused command done");
    rd_chk("unmapped", 32'h800, 32'h0);
    rd_chk("ctrl read", A_CTRL, 32'h0);
    rd_chk("pb id", {20'h0, `BIC_OFF_PB_ID}, cmd_id - 32'h1);
    rd_chk("pb am", A_AM, {16'h0, rows[2].am, 8'hfe});
    rd_chk("pb addr", {20'h0, `BIC_OFF_PB_ADDR}, rows[2].base);
    rd_chk("pb cmd", A_CMD, {8'h15, 6'h0, rows[2].fmt, 1'b0, 16'h0});
    rd_chk("tgt sync", 32'h44, 32'h2040_8000);
    $display("test map done");
    // Reset in the middle of a snapshot must drop the request at once
    prog(rows[0], `BIC_CMD_BOARD_INFO, `BIC_ADAPTER_CTRL_ID);
    wr(A_CTRL, 32'h1);
    do @(posedge clk_sys); while (vme_wr_req !== 1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("wr_req in reset", 32'h0, {31'h0, vme_wr_req});
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk("wr_req after reset", 32'h0, {31'h0, vme_wr_req});
    rd_chk("status after reset", A_STAT, 32'h0);
    rd_chk("gencfg after reset", A_GEN, `BIC_GENCFG_RST);
    rd_chk("table after reset", 32'h44, 32'h0);
    $display("test mid-run reset done");
    results();
  end

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      results();
    end
  end
endmodule

`default_nettype wire
